// ---- include/ame_regs.svh ----
// Timing counts and field constants for the alternate mode entry policy.
`ifndef AME_REGS_SVH
`define AME_REGS_SVH
`define AME_CLK_HZ 40000000
`define AME_TIMEOUT_MS 1000
`define AME_TIMEOUT_CYC ((`AME_TIMEOUT_MS) * (`AME_CLK_HZ / 1000))
`define AME_BUSY_WAIT_US 10
`define AME_BUSY_WAIT_CYC ((`AME_BUSY_WAIT_US) * (`AME_CLK_HZ / 1000000))
`define AME_SAFE_NS 1000
`define AME_SAFE_CYC (((`AME_SAFE_NS) * (`AME_CLK_HZ / 1000000) + 999) / 1000)
`define AME_MODE_W 3
`endif

// ---- include/ame_pkg.sv ----
// Types shared by both ends of the alternate mode entry policy.
package ame_pkg;
  typedef enum logic [2:0] {
    AME_CMD_DISCOVER = 3'h0,
    AME_CMD_ENTER = 3'h1,
    AME_CMD_EXIT = 3'h2,
    AME_CMD_POWER = 3'h3
  } ame_cmd_t;
  typedef enum logic [1:0] {
    AME_RSP_ACK = 2'h0,
    AME_RSP_BUSY = 2'h1,
    AME_RSP_NAK = 2'h2
  } ame_rsp_t;
endpackage : ame_pkg

// ---- include/ame_link_if.sv ----
// Structured message link between the requesting end and the device end.
interface ame_link_if;
  logic req_valid;
  ame_pkg::ame_cmd_t req_cmd;
  logic [2:0] req_mode;
  logic rsp_valid;
  ame_pkg::ame_rsp_t rsp_code;
  logic contract_ok;
  logic power_busy;
  modport host (output req_valid, output req_cmd, output req_mode,
    input rsp_valid, input rsp_code, output contract_ok,
    output power_busy);
  modport device (input req_valid, input req_cmd, input req_mode,
    output rsp_valid, output rsp_code, input contract_ok,
    input power_busy);
endinterface : ame_link_if

// ---- rtl/ame_safe_seq.sv ----
// Sequencer that parks lanes in the safe state around each mode change.
module ame_safe_seq #(
  parameter int SAFE_CYC = 1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Switch request and completion.
  input wire logic start,
  output logic done,
  output logic lanes_safe
);
  logic [7:0] cnt_q;
  logic busy_q;
  // Holds the lanes safe for SAFE_CYC cycles, then reports done.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= 8'(SAFE_CYC);
      end else if (busy_q) begin
        if (cnt_q <= 8'h01) begin
          busy_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  end
  assign lanes_safe = busy_q;
endmodule : ame_safe_seq

// ---- rtl/ame_host_end.sv ----
// Requesting end: issues structured requests and drives pin remapping.
`include "ame_regs.svh"
module ame_host_end #(
  parameter int BUSY_WAIT = `AME_BUSY_WAIT_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link toward the device end.
  ame_link_if.host link,
  // User side.
  input wire logic contract_in,
  input wire logic power_neg_in,
  input wire logic cmd_valid,
  input wire ame_pkg::ame_cmd_t cmd,
  input wire logic [2:0] cmd_mode,
  input wire logic remap_app,
  output logic cmd_ready,
  output logic done_pulse,
  output ame_pkg::ame_rsp_t done_code,
  output logic dpair_oe_n,
  output logic dpair_alt_en
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_BACKOFF} ame_hst_t;
  ame_hst_t st_q;
  ame_pkg::ame_cmd_t cmd_q;
  logic [15:0] bo_q;
  logic hiz_q, alt_q;
  wire logic can_send = link.contract_ok && !link.power_busy;
  wire logic is_enter = (cmd_q == ame_pkg::AME_CMD_ENTER);
  assign link.contract_ok = contract_in;
  assign link.power_busy = power_neg_in;
  assign cmd_ready = (st_q == H_IDLE) && can_send;
  assign link.req_valid = (st_q == H_IDLE) && cmd_valid && can_send &&
    (cmd != ame_pkg::AME_CMD_POWER);
  assign link.req_cmd = cmd;
  assign link.req_mode = cmd_mode;
  assign dpair_oe_n = hiz_q;
  assign dpair_alt_en = alt_q;
  // Request, wait for the single answer, back off after busy.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= H_IDLE;
      cmd_q <= ame_pkg::AME_CMD_DISCOVER;
      bo_q <= 16'h0000;
      hiz_q <= 1'b0;
      alt_q <= 1'b0;
      done_pulse <= 1'b0;
      done_code <= ame_pkg::AME_RSP_ACK;
    end else begin
      done_pulse <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (link.req_valid) begin
            cmd_q <= cmd;
            st_q <= H_WAIT;
            if (remap_app && cmd == ame_pkg::AME_CMD_ENTER) begin
              hiz_q <= 1'b1;
            end
            if (cmd == ame_pkg::AME_CMD_EXIT) begin
              alt_q <= 1'b0;
            end
          end
        end
        H_WAIT: begin
          if (link.rsp_valid) begin
            done_pulse <= 1'b1;
            done_code <= link.rsp_code;
            hiz_q <= 1'b0;
            if (is_enter && remap_app &&
                link.rsp_code == ame_pkg::AME_RSP_ACK) begin
              alt_q <= 1'b1; // Alternate use only after ACK.
            end
            if (link.rsp_code == ame_pkg::AME_RSP_BUSY) begin
              st_q <= H_BACKOFF;
              bo_q <= 16'(BUSY_WAIT);
            end else begin
              st_q <= H_IDLE;
            end
          end
        end
        H_BACKOFF: begin
          if (bo_q == 16'h0000) begin
            st_q <= H_IDLE;
          end else begin
            bo_q <= bo_q - 16'h0001;
          end
        end
      endcase
    end
  end
endmodule : ame_host_end

// ---- rtl/ame_device_end.sv ----
// Device end: answers structured requests and runs the entry timeout.
`include "ame_regs.svh"
// Summary of operation
// - Always present at least a basic USB interface (usb2_en is dropped when charger_only is set).
// - Modes change only through structured messages.
// - Billboard identifies device lacking equivalent function.
// - Modes only over direct links, never hubs.
// - Expander presents basic USB downstream.
// - Only structured commands change pin functions.
// - Hold requests during power negotiation.
// - One answer: ACK, BUSY or NAK.
// - Several modes may be active together.
// - No requests before explicit contract.
// - Finish mode switch, then send ACK.
// - Billboard after entry timeout without mode.
// - Defer billboard until tunnelling discovery ends.
// - Billboard optional when one mode suffices.
// - Late entry: ACK and withdraw billboard.
// - Data pair stays routed unless remapping.
// - Remapping design presents billboard after timeout.
// - High impedance before entry; alternate after ACK.
// - Lanes safe before any entry or exit.
module ame_device_end #(
  parameter int TIMEOUT_CYC = `AME_TIMEOUT_CYC,
  parameter int SAFE_CYC = `AME_SAFE_CYC,
  parameter int MODES = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link toward the requesting end.
  ame_link_if.device link,
  // Attach and configuration.
  input wire logic attached,
  input wire logic direct_link,
  input wire logic [MODES-1:0] modes_supported,
  input wire logic [MODES-1:0] modes_ready,
  input wire logic has_usb_equiv,
  input wire logic one_mode_ok,
  input wire logic tunnel_pending,
  input wire logic remap_app,
  input wire logic is_expander,
  input wire logic charger_only,
  // Status outputs.
  output logic [MODES-1:0] modes_active,
  output logic billboard_en,
  output logic usb2_en,
  output logic ds_usb2_en,
  output logic dpair_to_host,
  output logic lanes_safe,
  output logic timeout_flag
);
  typedef enum logic [1:0] {D_IDLE, D_SWITCH, D_ANSWER} ame_dst_t;
  ame_dst_t st_q;
  logic [31:0] tmo_q;
  logic tmo_q_hit;
  logic [MODES-1:0] act_q;
  logic [2:0] mode_q;
  logic enter_q;
  ame_pkg::ame_rsp_t rsp_q;
  logic rsp_v_q;
  logic sw_start, sw_done;

  // Request is accepted only when every precondition holds.
  wire logic legal = link.contract_ok && !link.power_busy &&
    direct_link;
  wire logic mode_ok = modes_supported[link.req_mode] &&
    (link.req_cmd != ame_pkg::AME_CMD_POWER);
  wire logic any_active = |act_q;
  ame_safe_seq #(.SAFE_CYC(SAFE_CYC)) u_safe (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .start(sw_start),
    .done(sw_done),
    .lanes_safe(lanes_safe)
  );
  // Start is dropped in the cycle done shows, so the lanes are not re-parked.
  assign sw_start = (st_q == D_SWITCH) && !sw_done;

  // Entry timeout counter, restarted at attach, stopped by entry.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !attached) begin
      tmo_q <= 32'h00000000;
      tmo_q_hit <= 1'b0;
    end else if (any_active) begin
      tmo_q <= 32'h00000000;
    end else if (tmo_q >= 32'(TIMEOUT_CYC)) begin
      tmo_q_hit <= 1'b1;
    end else begin
      tmo_q <= tmo_q + 32'h00000001;
    end
  end

  // Request handling: switch first, then answer once.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_q <= D_IDLE;
      act_q <= '0;
      mode_q <= 3'h0;
      enter_q <= 1'b0;
      rsp_q <= ame_pkg::AME_RSP_ACK;
      rsp_v_q <= 1'b0;
    end else begin
      rsp_v_q <= 1'b0;
      unique case (st_q)
        D_IDLE: begin
          if (link.req_valid) begin
            mode_q <= link.req_mode;
            enter_q <= (link.req_cmd == ame_pkg::AME_CMD_ENTER);
            if (!legal || !mode_ok) begin
              rsp_q <= ame_pkg::AME_RSP_NAK;
              st_q <= D_ANSWER;
            end else if (link.req_cmd == ame_pkg::AME_CMD_DISCOVER) begin
              rsp_q <= ame_pkg::AME_RSP_ACK;
              st_q <= D_ANSWER;
            end else if (!modes_ready[link.req_mode]) begin
              rsp_q <= ame_pkg::AME_RSP_BUSY;
              st_q <= D_ANSWER;
            end else begin
              rsp_q <= ame_pkg::AME_RSP_ACK;
              st_q <= D_SWITCH;
            end
          end
        end
        D_SWITCH: begin
          if (sw_done) begin
            act_q[mode_q] <= enter_q; // Switch done before ACK.
            st_q <= D_ANSWER;
          end
        end
        D_ANSWER: begin
          rsp_v_q <= 1'b1;
          st_q <= D_IDLE;
        end
      endcase
    end
  end

  assign link.rsp_valid = rsp_v_q;
  assign link.rsp_code = rsp_q;
  assign modes_active = act_q;
  assign timeout_flag = tmo_q_hit;
  // Basic USB always on except for plain chargers.
  assign usb2_en = !charger_only;
  assign ds_usb2_en = is_expander;
  // Data pair leaves the host controller only for an active remap.
  assign dpair_to_host = !(remap_app && any_active);
  // Billboard: after timeout, withdrawn once a mode is entered.
  assign billboard_en = attached && !any_active && !tunnel_pending &&
    tmo_q_hit && (!has_usb_equiv || remap_app) &&
    !(one_mode_ok && has_usb_equiv);
endmodule : ame_device_end

// ---- bench/ame_checker.sv ----
// Concurrent checks on the link between the two policy ends.
module ame_checker #(
  parameter int SAFE_CYC = 8,
  parameter int BUSY_WAIT = 20
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link signals.
  input wire logic req_valid,
  input wire ame_pkg::ame_cmd_t req_cmd,
  input wire logic [2:0] req_mode,
  input wire logic rsp_valid,
  input wire ame_pkg::ame_rsp_t rsp_code,
  input wire logic contract_ok,
  input wire logic power_busy
);
  localparam int RSP_MAX = SAFE_CYC + 8;
  logic pend_q;
  logic [15:0] wait_q;
  wire busy_rsp = rsp_valid && rsp_code == ame_pkg::AME_RSP_BUSY;
  wire ack_rsp = rsp_valid && rsp_code == ame_pkg::AME_RSP_ACK;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Tracks an open request and the hold-off after a busy answer.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      wait_q <= 16'h0000;
    end else begin
      pend_q <= req_valid | (pend_q & ~rsp_valid);
      wait_q <= busy_rsp ? 16'(BUSY_WAIT) : wait_q - 16'(wait_q != 0);
    end
  end
  a_req_contract: assert property (req_valid |-> contract_ok)
    else $error("request sent without contract");
  a_req_power: assert property (req_valid |-> !power_busy)
    else $error("request sent during power negotiation");
  a_req_kind: assert property (req_valid |-> req_cmd != ame_pkg::AME_CMD_POWER)
    else $error("power command sent as request");
  a_one_pending: assert property (req_valid |-> !pend_q)
    else $error("second request while one is open");
  a_rsp_has_req: assert property (rsp_valid |-> pend_q && rsp_code != 2'h3)
    else $error("answer without request or bad code");
  a_discover_turn: assert property (
    req_valid && req_cmd == ame_pkg::AME_CMD_DISCOVER |-> ##2 rsp_valid)
    else $error("discover answer late");
  a_switch_first: assert property (
    req_valid && req_cmd inside {ame_pkg::AME_CMD_ENTER, ame_pkg::AME_CMD_EXIT}
    |=> !ack_rsp [*8]) else $error("ack before switch done");
  a_answer_bound: assert property (req_valid |=> ##[0:RSP_MAX] rsp_valid)
    else $error("no answer to request");
  a_busy_hold: assert property (wait_q != 0 |-> !req_valid)
    else $error("retry too soon after busy");
  c_ack: cover property (ack_rsp);
  c_busy: cover property (busy_rsp);
  c_nak: cover property (rsp_valid && rsp_code == ame_pkg::AME_RSP_NAK);
endmodule : ame_checker

// ---- bench/ame_tb_top.sv ----
// Self-checking bench joining both policy ends over the link.
module ame_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, attached = 1'b0;
  logic remap_app = 1'b1, direct_link = 1'b1, has_usb_equiv = 1'b0;
  logic one_mode_ok = 1'b0, tunnel_pending = 1'b0, is_expander = 1'b0;
  logic [2:0] cmd_mode = 3'h0;
  logic [7:0] modes_supported = 8'h0F, modes_ready = 8'h07, modes_active;
  ame_pkg::ame_cmd_t cmd = ame_pkg::AME_CMD_DISCOVER;
  ame_pkg::ame_rsp_t done_code;
  logic cmd_ready, done_pulse, dpair_oe_n, dpair_alt_en, billboard_en;
  logic usb2_en, ds_usb2_en, dpair_to_host, lanes_safe, timeout_flag, safe_seen;
  logic hiz_seen, contract_in = 1'b1, power_neg_in = 1'b0;
  logic charger_only = 1'b0;
  int failures = 0, checked = 0, cycles = 0;
  ame_link_if link();
  ame_host_end #(.BUSY_WAIT(20)) ame_host_end_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .link(link), .contract_in(contract_in),
    .power_neg_in(power_neg_in),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_mode(cmd_mode),
    .remap_app(remap_app), .cmd_ready(cmd_ready), .done_pulse(done_pulse),
    .done_code(done_code), .dpair_oe_n(dpair_oe_n),
    .dpair_alt_en(dpair_alt_en));
  ame_device_end #(.TIMEOUT_CYC(50), .SAFE_CYC(8)) ame_device_end_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .attached(attached),
    .direct_link(direct_link), .modes_supported(modes_supported),
    .modes_ready(modes_ready), .has_usb_equiv(has_usb_equiv),
    .one_mode_ok(one_mode_ok), .tunnel_pending(tunnel_pending),
    .remap_app(remap_app), .is_expander(is_expander),
    .charger_only(charger_only),
    .modes_active(modes_active), .billboard_en(billboard_en),
    .usb2_en(usb2_en), .ds_usb2_en(ds_usb2_en), .dpair_to_host(dpair_to_host),
    .lanes_safe(lanes_safe), .timeout_flag(timeout_flag));
  ame_checker #(.SAFE_CYC(8), .BUSY_WAIT(20)) ame_checker_i (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .req_valid(link.req_valid), .req_cmd(link.req_cmd),
    .req_mode(link.req_mode), .rsp_valid(link.rsp_valid),
    .rsp_code(link.rsp_code), .contract_ok(link.contract_ok),
    .power_busy(link.power_busy));
  // Clock of 25 ns period.
  always #12.5 sys_clk = ~sys_clk;
  // Cuts a hung run short.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end
  // Compares one observed value with its expectation.
  task automatic chk(input string name, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk
  // Issues one request and waits for its completion code.
  task automatic run(input ame_pkg::ame_cmd_t c, input logic [2:0] m,
                     input ame_pkg::ame_rsp_t e);
    int n;
    n = 0;
    safe_seen = 1'b0;
    hiz_seen = 1'b0;
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_mode <= m;
    do @(posedge sys_clk); while (cmd_ready !== 1'b1 && ++n < 900);
    cmd_valid <= 1'b0;
    do begin
      @(posedge sys_clk);
      safe_seen |= lanes_safe;
      hiz_seen |= dpair_oe_n;
    end while (done_pulse !== 1'b1 && ++n < 900);
    chk("done_pulse", 8'(done_pulse), 8'h01);
    chk("done_code", 8'(done_code), 8'(e));
  endtask : run
  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Main sequence of requests and expectations.
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tunnel_pending <= 1'b1;
    attached <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("usb2_en", 8'(usb2_en), 8'h01);
    chk("dpair_to_host", 8'(dpair_to_host), 8'h01);
    repeat (60) @(posedge sys_clk);
    chk("timeout_flag", 8'(timeout_flag), 8'h01);
    chk("billboard_en", 8'(billboard_en), 8'h00);
    tunnel_pending <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("billboard_en", 8'(billboard_en), 8'h01);
    run(ame_pkg::AME_CMD_DISCOVER, 3'h0, ame_pkg::AME_RSP_ACK);
    run(ame_pkg::AME_CMD_ENTER, 3'h3, ame_pkg::AME_RSP_BUSY);
    repeat (2) @(posedge sys_clk);
    chk("modes_active", modes_active, 8'h00);
    chk("dpair_alt_en", 8'(dpair_alt_en), 8'h00);
    chk("hiz_seen", 8'(hiz_seen), 8'h01);
    chk("dpair_oe_n", 8'(dpair_oe_n), 8'h00);
    run(ame_pkg::AME_CMD_ENTER, 3'h5, ame_pkg::AME_RSP_NAK);
    run(ame_pkg::AME_CMD_ENTER, 3'h1, ame_pkg::AME_RSP_ACK);
    chk("lanes_safe", 8'(safe_seen), 8'h01);
    repeat (2) @(posedge sys_clk);
    chk("modes_active", modes_active, 8'h02);
    chk("billboard_en", 8'(billboard_en), 8'h00);
    chk("dpair_alt_en", 8'(dpair_alt_en), 8'h01);
    chk("dpair_oe_n", 8'(dpair_oe_n), 8'h00);
    chk("dpair_to_host", 8'(dpair_to_host), 8'h00);
    run(ame_pkg::AME_CMD_ENTER, 3'h0, ame_pkg::AME_RSP_ACK);
    chk("modes_active", modes_active, 8'h03);
    run(ame_pkg::AME_CMD_EXIT, 3'h1, ame_pkg::AME_RSP_ACK);
    chk("lanes_safe", 8'(safe_seen), 8'h01);
    chk("modes_active", modes_active, 8'h01);
    run(ame_pkg::AME_CMD_EXIT, 3'h0, ame_pkg::AME_RSP_ACK);
    repeat (2) @(posedge sys_clk);
    chk("billboard_en", 8'(billboard_en), 8'h01);
    chk("dpair_to_host", 8'(dpair_to_host), 8'h01);
    has_usb_equiv <= 1'b1;
    one_mode_ok <= 1'b1;
    is_expander <= 1'b1;
    direct_link <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("billboard_en", 8'(billboard_en), 8'h00);
    chk("ds_usb2_en", 8'(ds_usb2_en), 8'h01);
    one_mode_ok <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("billboard_en", 8'(billboard_en), 8'h01);
    remap_app <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("billboard_en", 8'(billboard_en), 8'h00);
    run(ame_pkg::AME_CMD_ENTER, 3'h2, ame_pkg::AME_RSP_NAK);
    chk("modes_active", modes_active, 8'h00);
    contract_in <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("cmd_ready", 8'(cmd_ready), 8'h00);
    contract_in <= 1'b1;
    power_neg_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("cmd_ready", 8'(cmd_ready), 8'h00);
    power_neg_in <= 1'b0;
    charger_only <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("usb2_en", 8'(usb2_en), 8'h00);
    chk("cmd_ready", 8'(cmd_ready), 8'h01);
    print_verdict();
  end
endmodule : ame_tb_top
